// >>> sbcd_consts.svh
`ifndef SBCD_CONSTS_SVH
`define SBCD_CONSTS_SVH
`define SBCD_DIV_W 8
`define SBCD_SEL_INTERNAL 1'b1
`define SBCD_SEL_EXTERNAL 1'b0
`define SBCD_CNT_ZERO 8'h00
`define SBCD_CNT_ONE 8'h01
`define SBCD_DIV_RESET 8'h01
`endif

// >>> sbcd_divider.sv
`timescale 1ns/100ps
`include "sbcd_consts.svh"
module sbcd_divider #(
  parameter int DIV_W = `SBCD_DIV_W
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire sbcd_pkg::sbcd_cfg_t I_CFG,
  input wire logic I_SHARED_PIN,
  output logic O_TX_BIT_CLOCK,
  output logic O_RX_BIT_CLOCK,
  output logic O_RX_BIT_CLOCK_OE
);
  logic pin_sync;
  logic pin_prev_q;
  logic pin_prev_d;
  logic src_tick;
  sbcd_pkg::sbcd_phase_t phase_q;
  sbcd_pkg::sbcd_phase_t phase_d;
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] high_len;
  logic [DIV_W-1:0] low_len;
  logic [DIV_W:0] half_up;
  logic tx_q;
  logic tx_d;
  logic rxo_q;
  logic rxo_d;
  logic oe_q;
  logic oe_d;

  sbcd_sync u_pin_sync (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_async(I_SHARED_PIN),
    .o_sync(pin_sync)
  );

  // Pin is sampled, so external source must run below half the system rate
  always_comb begin
    pin_prev_d = pin_sync;
    src_tick = 1'b1;
    if (I_CFG.input_clock_select == `SBCD_SEL_EXTERNAL) begin
      src_tick = I_CFG.rx_pin_is_source & pin_sync & ~pin_prev_q;
    end
  end

  // Phase lengths from the divide value latched at each period start
  always_comb begin
    half_up = ({1'b0, div_q} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
    if (div_q[0]) begin
      high_len = half_up[DIV_W-1:0];
      low_len = half_up[DIV_W-1:0];
    end else begin
      high_len = (div_q >> 1) + `SBCD_CNT_ONE;
      low_len = div_q >> 1;
    end
  end

  // Toggling only at counted boundaries keeps reselect glitch free
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    div_d = div_q;
    if (src_tick) begin
      case (phase_q)
        sbcd_pkg::SBCD_PH_HIGH: begin
          if (cnt_q + `SBCD_CNT_ONE >= high_len) begin
            cnt_d = `SBCD_CNT_ZERO;
            // Zero low length only for divide value zero: skip low phase
            if (low_len == `SBCD_CNT_ZERO) begin
              div_d = I_CFG.divide_value;
            end else begin
              phase_d = sbcd_pkg::SBCD_PH_LOW;
            end
          end else begin
            cnt_d = cnt_q + `SBCD_CNT_ONE;
          end
        end
        sbcd_pkg::SBCD_PH_LOW: begin
          if (cnt_q + `SBCD_CNT_ONE >= low_len) begin
            cnt_d = `SBCD_CNT_ZERO;
            phase_d = sbcd_pkg::SBCD_PH_HIGH;
            div_d = I_CFG.divide_value;
          end else begin
            cnt_d = cnt_q + `SBCD_CNT_ONE;
          end
        end
        default: begin
          phase_d = sbcd_pkg::SBCD_PH_HIGH;
          cnt_d = `SBCD_CNT_ZERO;
        end
      endcase
    end
  end

  // Zero-divide case keeps the clock high; that is the documented ratio
  always_comb begin
    tx_d = (phase_d == sbcd_pkg::SBCD_PH_HIGH);
    rxo_d = tx_d;
    oe_d = ~I_CFG.rx_pin_is_source;
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      pin_prev_q <= 1'b0;
      phase_q <= sbcd_pkg::SBCD_PH_HIGH;
      cnt_q <= `SBCD_CNT_ZERO;
      div_q <= `SBCD_DIV_RESET;
      tx_q <= 1'b1;
      rxo_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_prev_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      tx_q <= tx_d;
      rxo_q <= rxo_d;
      oe_q <= oe_d;
    end
  end

  assign O_TX_BIT_CLOCK = tx_q;
  assign O_RX_BIT_CLOCK = rxo_q;
  assign O_RX_BIT_CLOCK_OE = oe_q;

  sequence s_high_end;
    $fell(tx_q);
  endsequence

  sequence s_low_end;
    $rose(tx_q);
  endsequence

  // Clock and phase are both registered from phase_d
  a_tx_tracks_phase: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    tx_q == (phase_q == sbcd_pkg::SBCD_PH_HIGH))
    else $error("tx clock disagrees with phase");
  a_rx_eq_tx: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    rxo_q == tx_q)
    else $error("rx clock differs from tx clock");
  a_oe_follows_cfg: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    ##1 oe_q == ~$past(I_CFG.rx_pin_is_source))
    else $error("shared pin enable wrong");
  a_int_tick_always: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    I_CFG.input_clock_select |-> src_tick)
    else $error("internal source not counting");
  a_ext_no_pin: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (!I_CFG.input_clock_select && !I_CFG.rx_pin_is_source) |-> !src_tick)
    else $error("external source ticks without pin");
  a_cnt_in_range: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    phase_q == sbcd_pkg::SBCD_PH_LOW |-> cnt_q < low_len)
    else $error("low counter overrun");
  a_high_in_range: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    phase_q == sbcd_pkg::SBCD_PH_HIGH |-> cnt_q < high_len)
    else $error("high counter overrun");
  a_div2_low_len: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_high_end ##0 (div_q == 8'h02 && I_CFG.input_clock_select))
      |-> !tx_q ##1 tx_q)
    else $error("divide two low phase not one cycle");
  a_div1_high_len: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (s_low_end ##0 (div_q == `SBCD_CNT_ONE && I_CFG.input_clock_select))
      |=> !tx_q)
    else $error("divide one high phase not one cycle");
  // State moves only on a counted source tick
  a_phase_on_tick: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    !src_tick |=> $stable(phase_q) && $stable(cnt_q))
    else $error("phase moved without source tick");
  a_div_at_boundary: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    $changed(div_q) |-> cnt_q == `SBCD_CNT_ZERO
      && phase_q == sbcd_pkg::SBCD_PH_HIGH)
    else $error("divide value reloaded mid period");
  a_zero_div_high: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    div_q == `SBCD_CNT_ZERO |-> tx_q)
    else $error("zero divide clock not high");
  a_ext_freeze: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (!I_CFG.input_clock_select && !I_CFG.rx_pin_is_source)
      |=> $stable(tx_q))
    else $error("clock moved with no source");
  a_low_len_nonzero: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    phase_q == sbcd_pkg::SBCD_PH_LOW |-> low_len != `SBCD_CNT_ZERO)
    else $error("low phase entered with zero length");
  a_odd_equal: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    div_q[0] |-> high_len == low_len)
    else $error("odd divide phases unequal");
  a_even_longer: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    !div_q[0] |-> high_len == low_len + `SBCD_CNT_ONE)
    else $error("even divide high not one longer");
  // Pin edges are at least two system cycles apart after sync
  a_ext_tick_gap: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (src_tick && !I_CFG.input_clock_select) |=> !src_tick)
    else $error("external source ticked twice in a row");
  a_high_to_low: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    ($past(phase_q) == sbcd_pkg::SBCD_PH_HIGH
      && phase_q == sbcd_pkg::SBCD_PH_LOW)
      |-> $past(cnt_q) + `SBCD_CNT_ONE == $past(high_len))
    else $error("high phase ended early");
  a_low_to_high: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    ($past(phase_q) == sbcd_pkg::SBCD_PH_LOW
      && phase_q == sbcd_pkg::SBCD_PH_HIGH)
      |-> $past(cnt_q) + `SBCD_CNT_ONE == $past(low_len))
    else $error("low phase ended early");
  a_no_stall_int: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (I_CFG.input_clock_select && div_q != `SBCD_CNT_ZERO)
      |-> ##[1:300] $changed(tx_q))
    else $error("bit clock stalled");
endmodule

// >>> sbcd_pkg.sv
package sbcd_pkg;
  typedef struct packed {
    logic input_clock_select;
    logic rx_pin_is_source;
    logic [7:0] divide_value;
  } sbcd_cfg_t;
  typedef enum logic [1:0] {
    SBCD_PH_HIGH = 2'b01,
    SBCD_PH_LOW = 2'b10
  } sbcd_phase_t;
endpackage

// >>> sbcd_src_model.sv
`timescale 1ns/100ps
module sbcd_src_model #(
  parameter int HALF_NS = 30
) (
  input wire logic i_en,
  output logic o_src
);
  // Offset keeps source edges away from system clock edges
  initial begin
    o_src = 1'b0;
    #3;
    forever begin
      #HALF_NS;
      o_src = i_en ? ~o_src : 1'b0;
    end
  end
endmodule

// >>> sbcd_sync.sv
`timescale 1ns/100ps
module sbcd_sync (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign o_sync = sync_q;
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic rst;
  logic src_en;
  logic src;
  logic tx;
  logic rx;
  logic oe;
  sbcd_pkg::sbcd_cfg_t cfg;
  int mismatches = 0;
  int tests_run = 0;
  sbcd_divider dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_CFG(cfg),
    .I_SHARED_PIN(src), .O_TX_BIT_CLOCK(tx), .O_RX_BIT_CLOCK(rx),
    .O_RX_BIT_CLOCK_OE(oe));
  sbcd_src_model model (.i_en(src_en), .o_src(src));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // Cycles until tx shows lvl, bounded
  task automatic wait_lvl(logic lvl, output int n);
    n = 0;
    while (tx !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 4000) begin
        mismatches++;
        end_sim();
      end
    end
  endtask
  task automatic meas(output int h, output int l);
    int n;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, h);
    wait_lvl(1'b1, l);
  endtask
  task automatic t_internal;
    int h;
    int l;
    int nv [5] = '{1, 2, 3, 4, 7};
    foreach (nv[i]) begin
      cfg = '{1'b1, 1'b1, nv[i][7:0]};
      meas(h, l);
      meas(h, l);
      chk("high", nv[i] % 2 ? (nv[i] + 1) / 2 : nv[i] / 2 + 1, h);
      chk("low", nv[i] % 2 ? (nv[i] + 1) / 2 : nv[i] / 2, l);
      chk("rx", tx, rx);
    end
    $display("internal source done");
  endtask
  task automatic t_zero;
    int n = 0;
    cfg = '{1'b1, 1'b1, 8'h00};
    repeat (20) @(negedge clk);
    repeat (40) begin
      @(negedge clk);
      if (tx !== 1'b1) n++;
    end
    chk("zero divide", 0, n);
    $display("zero divide done");
  endtask
  task automatic t_external;
    int h;
    int l;
    src_en = 1'b1;
    cfg = '{1'b0, 1'b1, 8'h02};
    meas(h, l);
    meas(h, l);
    chk("ext high", 12, h);
    chk("ext low", 6, l);
    chk("oe off", 0, oe);
    $display("external source done");
  endtask
  task automatic t_frozen;
    int n = 0;
    logic last;
    cfg = '{1'b0, 1'b0, 8'h02};
    repeat (3) @(negedge clk);
    last = tx;
    repeat (60) begin
      @(negedge clk);
      if (tx !== last) n++;
    end
    chk("frozen", 0, n);
    chk("oe on", 1, oe);
    $display("pin as output done");
  endtask
  initial begin
    cfg = '{1'b1, 1'b1, 8'h01};
    src_en = 1'b0;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    chk("reset tx", 1, tx);
    chk("reset oe", 0, oe);
    rst = 1'b0;
    t_internal();
    t_zero();
    t_external();
    t_frozen();
    end_sim();
  end
endmodule
